// ==== verilog/dcrs_top.sv ====
// Operation
// R1 - Core is in reset while the active-low reset pin is low.
// R2 - Reset clears the vector-table page pointer to zero.
// R3 - After reset the first fetch address is program address zero.
// R4 - Reset clears all pending interrupt flags.
// R5 - Reset sets the global interrupt-disable bit in status word zero.
// R6 - Reset leaves saturation, test flag, mask, aux pointers, data page.
// R7 - Held state while reset low; fetch starts at vector after release.
`timescale 1ns/1ps
`default_nettype none
module dcrs_top (
	// Clock and board reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Interrupt request lines (already on clk_sys_i)
	input wire logic [15:0] irq_i,
	// Fetch
	output logic [15:0] fetch_addr_o,
	output logic fetch_en_o,
	output logic intr_pending_o,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {ST_RESET, ST_VECTOR, ST_RUN} dcrs_state_type;
	dcrs_state_type state_q;
	logic [15:0] flags_q;
	logic intdis_q;
	logic [dcrs_pkg::VPAGE_W-1:0] vpage_q;
	// Never reset: power-up contents are left undefined
	logic sat_mode_q, test_flag_q;
	logic [15:0] mask_q;
	logic [2:0] aux_sel_q, aux_buf_q;
	logic [8:0] data_page_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic [31:0] rd_val;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Both channels held and no response still waiting
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// -------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------
	// R1 core in reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_RESET;
		end else begin
			case (state_q)
				ST_RESET: state_q <= ST_VECTOR;
				ST_VECTOR: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_RESET;
			endcase
		end
	end

	// R3 fetch from vector zero
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fetch_addr_o <= dcrs_pkg::RESET_VECTOR;
			fetch_en_o <= 1'b0;
		end else begin
			// R7 fetch begins after release
			fetch_en_o <= (state_q != ST_RESET);
			if (state_q == ST_RUN) begin
				fetch_addr_o <= fetch_addr_o + 16'h0001;
			end else begin
				fetch_addr_o <= {vpage_q, 11'h000};
			end
		end
	end

	// -------------------------------------------------------------
	// Architectural state
	// -------------------------------------------------------------
	// R4 pending flags cleared
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_q <= dcrs_pkg::FLAGS_RST;
		end else if (wr_go && awaddr_q == dcrs_pkg::FLAGS_OFF) begin
			// Write one to clear; a new request wins over the clear
			flags_q <= (flags_q & ~wdata_q[15:0]) | irq_i;
		end else begin
			flags_q <= flags_q | irq_i;
		end
	end

	// R5 interrupts disabled
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			intdis_q <= 1'b1;
		end else if (wr_go && awaddr_q == dcrs_pkg::STATUS_OFF && wstrb_q[0]) begin
			intdis_q <= wdata_q[dcrs_pkg::INTDIS_BIT];
		end
	end

	// R2 vector page cleared
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			vpage_q <= dcrs_pkg::VPAGE_RST;
		end else if (wr_go && awaddr_q == dcrs_pkg::CTRL_OFF && wstrb_q[1]) begin
			vpage_q <= wdata_q[dcrs_pkg::VPAGE_LSB +: dcrs_pkg::VPAGE_W];
		end
	end

	// R6 left untouched by reset
	always_ff @(posedge clk_sys_i) begin
		if (wr_go && awaddr_q == dcrs_pkg::STATUS_OFF && wstrb_q[0]) begin
			sat_mode_q <= wdata_q[dcrs_pkg::SAT_BIT];
			test_flag_q <= wdata_q[dcrs_pkg::TFLAG_BIT];
		end
		if (wr_go && awaddr_q == dcrs_pkg::MASK_OFF) begin
			mask_q <= merge16(mask_q, wdata_q, wstrb_q);
		end
		if (wr_go && awaddr_q == dcrs_pkg::AUX_OFF) begin
			if (wstrb_q[0]) begin
				aux_sel_q <= wdata_q[2:0];
				aux_buf_q <= wdata_q[6:4];
			end
			if (wstrb_q[1]) begin
				data_page_q <= {wdata_q[8], wdata_q[15:8]};
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			intr_pending_o <= 1'b0;
		end else begin
			intr_pending_o <= !intdis_q && |(flags_q & mask_q);
		end
	end

	// -------------------------------------------------------------
	// AXI4-Lite slave
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dcrs_pkg::AXI_OKAY;
		end else begin
			// Ready drops while a channel is held, so a second
			// address or word waits until the pair is consumed
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q <= dcrs_pkg::AUX_OFF) ?
					dcrs_pkg::AXI_OKAY : dcrs_pkg::AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		case ({s_axi_araddr[7:2], 2'b00})
			dcrs_pkg::CTRL_OFF: rd_val = {16'h0000, vpage_q, 11'h000};
			dcrs_pkg::STATUS_OFF: rd_val = {29'h0, test_flag_q, sat_mode_q,
				intdis_q};
			dcrs_pkg::FLAGS_OFF: rd_val = {16'h0000, flags_q};
			dcrs_pkg::MODE_OFF: rd_val = {30'h0, state_q};
			dcrs_pkg::MASK_OFF: rd_val = {16'h0000, mask_q};
			dcrs_pkg::AUX_OFF: rd_val = {16'h0000, data_page_q[7:0],
				data_page_q[8], aux_buf_q, 1'b0, aux_sel_q};
			dcrs_pkg::PC_OFF: rd_val = {16'h0000, fetch_addr_o};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dcrs_pkg::AXI_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= ({s_axi_araddr[7:2], 2'b00} <=
					dcrs_pkg::PC_OFF) ?
					dcrs_pkg::AXI_OKAY : dcrs_pkg::AXI_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	sequence s_release;
		$rose(resetn_i) ##0 state_q == ST_RESET;
	endsequence

	a_vector_first_fetch: assert property (@(posedge clk_sys_i) // R3
		s_release |=> fetch_addr_o == dcrs_pkg::RESET_VECTOR ##1 fetch_en_o)
		else $error("first fetch not at reset vector");
	a_fetch_held_reset: assert property (@(posedge clk_sys_i) // R7
		state_q == ST_RESET |=> !fetch_en_o)
		else $error("fetch enabled during reset");
	a_flags_clear_out: assert property (@(posedge clk_sys_i) // R4
		s_release |-> flags_q == dcrs_pkg::FLAGS_RST)
		else $error("pending flags survived reset");
	a_intdis_set_out: assert property (@(posedge clk_sys_i) // R5
		s_release |-> intdis_q)
		else $error("interrupt disable not set by reset");
	a_vpage_zero_out: assert property (@(posedge clk_sys_i) // R2
		s_release |-> vpage_q == dcrs_pkg::VPAGE_RST)
		else $error("vector page not cleared by reset");
	a_reset_state_enter: assert property (@(posedge clk_sys_i) // R1
		!resetn_i |-> state_q == ST_RESET)
		else $error("core not in reset while pin low");
	a_intr_blocked_dis: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i) intdis_q [*2] |-> !intr_pending_o) // R5
		else $error("interrupt raised while disabled");
	a_flag_set_wins: assert property (@(posedge clk_sys_i)
		disable iff (!resetn_i) irq_i[0] |=> flags_q[0]) // R4
		else $error("request lost on clear");
endmodule
`default_nettype wire

// ==== verilog/dcrs_pkg.sv ====
`default_nettype none
package dcrs_pkg;
	// Register offsets (byte addresses, word aligned)
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] FLAGS_OFF = 8'h08;
	localparam logic [7:0] MODE_OFF = 8'h0c;
	localparam logic [7:0] MASK_OFF = 8'h10;
	localparam logic [7:0] AUX_OFF = 8'h14;
	localparam logic [7:0] PC_OFF = 8'h18;
	// Field positions in status word zero
	localparam int INTDIS_BIT = 0;
	localparam int SAT_BIT = 1;
	localparam int TFLAG_BIT = 2;
	// Field positions in processor mode status word
	localparam int VPAGE_LSB = 11;
	localparam int VPAGE_W = 5;
	// Reset values
	localparam logic [VPAGE_W-1:0] VPAGE_RST = 5'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== bench/dcrs_reset_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// Board reset source
// ----------------------------
module dcrs_reset_src (
	// Clock
	input wire logic clk_sys_i,
	// Reset pin
	output logic resetn_o
);
	// No initial value: the first pulse gives a clean falling edge
	// low requests reset
	task automatic pulse(input int n);
		resetn_o <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		resetn_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== bench/dcrs_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcrs_top_tb;
	logic clk_sys_i = 1'b0;
	logic resetn_i;
	logic [15:0] irq_i = 16'h0000;
	logic [15:0] fetch_addr_o;
	logic fetch_en_o, intr_pending_o;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [17:0] exp_q[$], msk_q[$];
	logic [15:0] mask_v, aux_v, st_v, irq_v;
	int mismatches = 0, total_checks = 0, cyc = 0, seed = 43;
	always #2 clk_sys_i = ~clk_sys_i;
	dcrs_reset_src rst (.clk_sys_i, .resetn_o(resetn_i));
	dcrs_top DUT (.clk_sys_i, .resetn_i, .irq_i, .fetch_addr_o, .fetch_en_o,
		.intr_pending_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// ----------------------------
	// Checking
	// ----------------------------
	task automatic cmp(input logic [31:0] g, e, m);
		total_checks++;
		if ((g & m) !== (e & m)) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask
	// Read results carry the response code above the low half
	always @(posedge clk_sys_i) begin
		if (s_axi_rvalid && s_axi_rready) begin
			cmp({s_axi_rresp, s_axi_rdata[15:0]}, exp_q.pop_front(),
				msk_q.pop_front());
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// ----------------------------
	// Drivers
	// ----------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge clk_sys_i); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge clk_sys_i); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		while (!s_axi_bvalid) @(posedge clk_sys_i);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [17:0] e, m);
		@(posedge clk_sys_i);
		exp_q.push_back(e);
		msk_q.push_back(m);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys_i); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk_sys_i);
		s_axi_rready <= 1'b0;
	endtask
	// Checks at the release edge still see the in-reset values
	task automatic boot();
		rst.pulse(4);
		cmp(fetch_en_o, 0, 1);
		cmp(intr_pending_o, 0, 1);
		@(posedge clk_sys_i);
		#1 cmp(fetch_en_o, 0, 1);
		@(posedge clk_sys_i);
		#1 cmp({fetch_en_o, fetch_addr_o}, 32'h10000, 32'h1ffff);
		@(posedge clk_sys_i);
		#1 cmp(fetch_addr_o, 1, 32'hffff);
		$display("Test boot done");
	endtask
	// ----------------------------
	// Scenarios
	// ----------------------------
	initial begin
		boot();
		rd(dcrs_pkg::STATUS_OFF, 18'h1, 18'h1);
		rd(dcrs_pkg::FLAGS_OFF, 18'h0, 18'hffff);
		rd(dcrs_pkg::CTRL_OFF, 18'h0, 18'hf800);
		rd(8'h1c, {dcrs_pkg::AXI_SLVERR, 16'h0}, 18'h3ffff);
		$display("Test reset values done");
		mask_v = 16'($random(seed)) | 16'h0001;
		aux_v = 16'($random(seed)) & 16'hff77;
		st_v = 16'($random(seed)) & 16'h0006;
		irq_v = 16'($random(seed)) | 16'h0001;
		wr(dcrs_pkg::MASK_OFF, mask_v);
		wr(dcrs_pkg::AUX_OFF, aux_v);
		wr(dcrs_pkg::STATUS_OFF, st_v);
		wr(dcrs_pkg::CTRL_OFF, 16'hf800);
		irq_i <= irq_v;
		@(posedge clk_sys_i);
		irq_i <= 16'h0000;
		rd(dcrs_pkg::FLAGS_OFF, {2'b00, irq_v}, 18'hffff);
		cmp(intr_pending_o, 1, 1);
		// Clear all flags while request 0 stays high: the set wins
		irq_i <= 16'h0001;
		wr(dcrs_pkg::FLAGS_OFF, 16'hffff);
		irq_i <= 16'h0000;
		rd(dcrs_pkg::FLAGS_OFF, 18'h00001, 18'h0ffff);
		rd(dcrs_pkg::CTRL_OFF, 18'hf800, 18'hf800);
		$display("Test setup done");
		// Mid-run reset with flags pending and a nonzero page
		boot();
		rd(dcrs_pkg::FLAGS_OFF, 18'h0, 18'hffff);
		rd(dcrs_pkg::CTRL_OFF, 18'h0, 18'hf800);
		rd(dcrs_pkg::STATUS_OFF, {2'b00, st_v | 16'h1}, 18'h7);
		rd(dcrs_pkg::MASK_OFF, {2'b00, mask_v}, 18'hffff);
		rd(dcrs_pkg::AUX_OFF, {2'b00, aux_v}, 18'hff77);
		cmp(intr_pending_o, 0, 1);
		$display("Test mid-run reset done");
		@(posedge clk_sys_i);
		tally_and_finish();
	end
endmodule
`default_nettype wire
